// *** design/dcam_map.vh ***
// Constants for the DMA channel address multiplexer
`ifndef DCAM_MAP_VH
`define DCAM_MAP_VH
`define DCAM_PTR_W 20
`define DCAM_REG_W 8
`define DCAM_NCH 27
`define DCAM_CH_BLT 0
`define DCAM_CH_BPL 4
`define DCAM_CH_COP 12
`define DCAM_CH_AUD 13
`define DCAM_CH_SPR 17
`define DCAM_CH_DSK 25
`define DCAM_CH_REF 26
`define DCAM_SLOTS 16
`define DCAM_SLOT_REF 0
`define DCAM_SLOT_DSK 4
`define DCAM_SLOT_AUD 5
`define DCAM_SLOT_SPR 8
`define DCAM_REF_CODE 8'h3C
`define DCAM_DST_BLT 8'h00
`define DCAM_DST_BPL 8'h88
`define DCAM_DST_COP 8'h44
`define DCAM_DST_AUD 8'hAA
`define DCAM_DST_SPR 8'h90
`define DCAM_DST_DSK 8'h08
`define DCAM_OP_MOVE 2'd0
`define DCAM_OP_SKIP 2'd1
`define DCAM_OP_JUMP 2'd2
`define DCAM_OP_WAIT 2'd3
`define DCAM_FIFO_DEPTH 8
`endif

// *** design/dcam_fifo.v ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dcam_fifo #(
	parameter WIDTH = 28,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;
	assign in_ready = (cnt != DEPTH[AW:0]);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always @(posedge clk) begin
		if (push)
			mem[wp] <= in_data;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
			if (pop)
				rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule // dcam_fifo

// *** design/dcam_top.v ***
// DMA channel address generator and host address multiplexer
`timescale 1ns/1ps
`include "dcam_map.vh"
module dcam_top #(
	parameter NCH = `DCAM_NCH,
	parameter TWO_MEG = 0
) (
	input wire MCLK,
	input wire RST,
	input wire [20:1] HOST_ADDR,
	input wire ADDR_STROBE_N,
	input wire MEMORY_SELECT_N,
	input wire REGS_SELECT_N,
	input wire LOWER_BYTE_STROBE_N,
	input wire UPPER_BYTE_STROBE_N,
	input wire HOST_READ_WRITE,
	input wire [3:0] SLOT_REQUEST_IN,
	input wire DISK_REQ,
	input wire DISK_WRITE,
	input wire [3:0] SLOT,
	input wire SLOT_TICK,
	input wire HBLANK,
	input wire DISPLAY_ACTIVE,
	input wire [15:0] BEAM_POS,
	input wire BLIT_START,
	input wire [3:0] BLIT_USE,
	input wire [7:0] SPRITE_EN,
	input wire [7:0] PLANE_EN,
	input wire COP_START,
	input wire PTR_LOAD,
	input wire [4:0] PTR_SEL,
	input wire [19:0] PTR_DATA,
	input wire FETCH_VALID,
	input wire [31:0] FETCH_DATA,
	output reg [9:0] MEM_ADDR_BUS,
	output reg [8:1] REG_DEST_BUS,
	output reg BUS_STEAL_N,
	output reg ROW_STROBE_N,
	output reg ROW_STROBE_BANK0_N,
	output reg ROW_STROBE_BANK1_N,
	output reg COL_STROBE_UPPER_N,
	output reg COL_STROBE_LOWER_N,
	output reg REG_READ_WRITE_OUT,
	output reg COL_PHASE,
	output reg XFER_DONE,
	output reg [4:0] XFER_CH,
	output reg COP_REG_WRITE,
	output reg [7:0] COP_REG_ADDR,
	output reg [15:0] COP_REG_DATA
);
	// Two-flop synchronisers for pin inputs
	reg [20:1] a_s1, a_s2;
	reg [5:0] c_s1, c_s2;
	reg [3:0] aud_s1, aud_s2;
	reg dsk_s1, dsk_s2;
	reg dwr_s1, dwr_s2;
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			a_s1 <= 20'h0_0000;
			a_s2 <= 20'h0_0000;
			c_s1 <= 6'h3F;
			c_s2 <= 6'h3F;
			aud_s1 <= 4'h0;
			aud_s2 <= 4'h0;
			dsk_s1 <= 1'b0;
			dsk_s2 <= 1'b0;
			dwr_s1 <= 1'b0;
			dwr_s2 <= 1'b0;
		end else begin
			a_s1 <= HOST_ADDR;
			a_s2 <= a_s1;
			c_s1 <= {ADDR_STROBE_N, MEMORY_SELECT_N, REGS_SELECT_N,
				LOWER_BYTE_STROBE_N, UPPER_BYTE_STROBE_N, HOST_READ_WRITE};
			c_s2 <= c_s1;
			aud_s1 <= SLOT_REQUEST_IN;
			aud_s2 <= aud_s1;
			dsk_s1 <= DISK_REQ;
			dsk_s2 <= dsk_s1;
			dwr_s1 <= DISK_WRITE;
			dwr_s2 <= dwr_s1;
		end
	end
	wire as_n = c_s2[5];
	wire ms_n = c_s2[4];
	wire rs_n = c_s2[3];
	wire lds_n = c_s2[2];
	wire uds_n = c_s2[1];
	wire hrw = c_s2[0];

	// Pointer file, one per channel
	reg [19:0] ptr [0:NCH-1];
	reg [19:0] cop_jump;
	wire [19:0] cur_ptr;
	reg grant_v;
	reg [4:0] grant_ch;
	assign cur_ptr = ptr[grant_ch];
	reg cop_jump_do;
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ptr
			always @(posedge MCLK or posedge RST) begin
				if (RST)
					ptr[g] <= 20'h0_0000;
				else if (g == `DCAM_CH_COP && cop_jump_do)
					ptr[g] <= cop_jump;
				else if (PTR_LOAD && PTR_SEL == g)
					ptr[g] <= PTR_DATA;
				else if (XFER_DONE && XFER_CH == g && g != `DCAM_CH_REF)
					ptr[g] <= ptr[g] + 20'h0_0001;
				else if (XFER_DONE && XFER_CH == g)
					ptr[g] <= ptr[g] + 20'h0_0200;
			end
		end
	endgenerate

	// Request sources
	reg [3:0] blit_act;
	reg [2:0] bpl_cnt;
	reg [1:0] cop_st;
	reg [15:0] cop_wait;
	localparam COP_IDLE = 2'd0;
	localparam COP_FETCH = 2'd1;
	localparam COP_WAIT = 2'd2;
	localparam COP_SKIP = 2'd3;
	wire cop_req = (cop_st == COP_FETCH) || (cop_st == COP_SKIP);
	wire cop_ready;
	reg [NCH-1:0] req;
	integer k;
	always @* begin
		req = {NCH{1'b0}};
		for (k = 0; k < 4; k = k + 1)
			req[`DCAM_CH_BLT + k] = blit_act[k];
		for (k = 0; k < 8; k = k + 1)
			req[`DCAM_CH_BPL + k] = DISPLAY_ACTIVE && PLANE_EN[k];
		req[`DCAM_CH_COP] = cop_req && cop_ready;
		for (k = 0; k < 4; k = k + 1)
			req[`DCAM_CH_AUD + k] = aud_s2[k] && HBLANK
				&& SLOT == (`DCAM_SLOT_AUD + k);
		for (k = 0; k < 8; k = k + 1)
			req[`DCAM_CH_SPR + k] = SPRITE_EN[k] && SLOT == (`DCAM_SLOT_SPR + k);
		req[`DCAM_CH_DSK] = dsk_s2 && SLOT == `DCAM_SLOT_DSK;
		req[`DCAM_CH_REF] = SLOT == `DCAM_SLOT_REF;
	end

	// refresh first, then lowest channel number
	localparam [4:0] REF_CH = `DCAM_CH_REF;
	reg next_v;
	reg [4:0] next_ch;
	always @* begin
		next_v = 1'b0;
		next_ch = 5'd0;
		for (k = NCH - 1; k >= 0; k = k - 1) begin
			if (req[k]) begin
				next_v = 1'b1;
				next_ch = k[4:0];
			end
		end
		if (req[`DCAM_CH_REF]) begin
			next_v = 1'b1;
			next_ch = REF_CH;
		end
	end

	// DMA cycle phases
	localparam PH_IDLE = 2'd0;
	localparam PH_ROW = 2'd1;
	localparam PH_COL = 2'd2;
	localparam PH_END = 2'd3;
	reg [1:0] ph;
	wire host_mem = !as_n && !ms_n;
	wire host_reg = !as_n && !rs_n;
	wire is_ref = grant_ch == `DCAM_CH_REF;
	wire dsk_w = dwr_s2;

	function [7:0] dest_code;
		input [4:0] ch;
		begin
			if (ch < `DCAM_CH_BPL)
				dest_code = `DCAM_DST_BLT + {3'd0, ch};
			else if (ch < `DCAM_CH_COP)
				dest_code = `DCAM_DST_BPL + {3'd0, ch - 5'd4};
			else if (ch == `DCAM_CH_COP)
				dest_code = `DCAM_DST_COP;
			else if (ch < `DCAM_CH_SPR)
				dest_code = `DCAM_DST_AUD + {3'd0, ch - 5'd13};
			else if (ch < `DCAM_CH_DSK)
				dest_code = `DCAM_DST_SPR + {3'd0, ch - 5'd17};
			else if (ch == `DCAM_CH_DSK)
				dest_code = `DCAM_DST_DSK;
			else
				dest_code = `DCAM_REF_CODE;
		end
	endfunction

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ph <= PH_IDLE;
			grant_v <= 1'b0;
			grant_ch <= 5'd0;
			XFER_DONE <= 1'b0;
			XFER_CH <= 5'd0;
		end else begin
			XFER_DONE <= 1'b0;
			case (ph)
				PH_IDLE: begin
					if (SLOT_TICK && next_v) begin
						grant_v <= 1'b1;
						grant_ch <= next_ch;
						ph <= PH_ROW;
					end
				end
				PH_ROW: begin
					ph <= PH_COL;
				end
				PH_COL: begin
					ph <= PH_END;
				end
				PH_END: begin
					XFER_DONE <= 1'b1;
					XFER_CH <= grant_ch;
					grant_v <= 1'b0;
					ph <= PH_IDLE;
				end
				default: begin
					ph <= PH_IDLE;
				end
			endcase
		end
	end

	// Output multiplexer
	reg [9:0] next_ma;
	reg [8:1] next_rga;
	reg next_steal_n, next_ras_n, next_r0_n, next_r1_n, next_cu_n, next_cl_n;
	reg next_rrw, next_col;
	always @* begin
		next_ma = 10'h3FF;
		next_rga = 8'hFF;
		next_steal_n = 1'b1;
		next_ras_n = 1'b1;
		next_r0_n = 1'b1;
		next_r1_n = 1'b1;
		next_cu_n = 1'b1;
		next_cl_n = 1'b1;
		next_rrw = 1'b1;
		next_col = 1'b0;
		if (grant_v) begin
			next_steal_n = 1'b0;
			next_col = (ph == PH_COL) || (ph == PH_END);
			next_ma = next_col ? {cur_ptr[19], cur_ptr[17], cur_ptr[7:0]}
				: {cur_ptr[18], cur_ptr[16:8]};
			next_rga = dest_code(grant_ch);
			next_rrw = !(grant_ch == `DCAM_CH_BLT + 3 || (grant_ch == `DCAM_CH_DSK && dsk_w));
			next_ras_n = 1'b0;
			if (is_ref) begin
				next_r0_n = 1'b0;
				next_r1_n = 1'b0;
				next_rrw = 1'b1;
			end else begin
				next_r0_n = (TWO_MEG != 0) ? 1'b1 : cur_ptr[18];
				next_r1_n = (TWO_MEG != 0) ? 1'b1 : !cur_ptr[18];
				next_cu_n = !next_col;
				next_cl_n = !next_col;
			end
		end else begin
			if (host_mem) begin
				next_col = 1'b1;
				next_ma = {a_s2[20], a_s2[18], a_s2[8:1]};
				next_ras_n = 1'b0;
				next_r0_n = (TWO_MEG != 0) ? 1'b1 : a_s2[19];
				next_r1_n = (TWO_MEG != 0) ? 1'b1 : !a_s2[19];
				next_cl_n = lds_n;
				next_cu_n = uds_n;
				next_rrw = hrw;
			end
			if (host_reg) begin
				next_rga = a_s2[8:1];
				next_rrw = hrw;
			end
		end
	end

	// Host row phase precedes column phase by one cycle
	reg host_row_done;
	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			host_row_done <= 1'b0;
			MEM_ADDR_BUS <= 10'h3FF;
			REG_DEST_BUS <= 8'hFF;
			BUS_STEAL_N <= 1'b1;
			ROW_STROBE_N <= 1'b1;
			ROW_STROBE_BANK0_N <= 1'b1;
			ROW_STROBE_BANK1_N <= 1'b1;
			COL_STROBE_UPPER_N <= 1'b1;
			COL_STROBE_LOWER_N <= 1'b1;
			REG_READ_WRITE_OUT <= 1'b1;
			COL_PHASE <= 1'b0;
		end else begin
			host_row_done <= host_mem && !grant_v;
			if (host_mem && !grant_v && !host_row_done) begin
				MEM_ADDR_BUS <= {a_s2[19], a_s2[17:9]};
				COL_STROBE_UPPER_N <= 1'b1;
				COL_STROBE_LOWER_N <= 1'b1;
				COL_PHASE <= 1'b0;
			end else begin
				MEM_ADDR_BUS <= next_ma;
				COL_STROBE_UPPER_N <= next_cu_n;
				COL_STROBE_LOWER_N <= next_cl_n;
				COL_PHASE <= next_col;
			end
			REG_DEST_BUS <= next_rga;
			BUS_STEAL_N <= next_steal_n;
			ROW_STROBE_N <= next_ras_n;
			ROW_STROBE_BANK0_N <= next_r0_n;
			ROW_STROBE_BANK1_N <= next_r1_n;
			REG_READ_WRITE_OUT <= next_rrw;
		end
	end

	// Image engine runs its four channels in order
	always @(posedge MCLK or posedge RST) begin
		if (RST)
			blit_act <= 4'h0;
		else if (BLIT_START)
			blit_act <= BLIT_USE;
		else if (XFER_DONE && XFER_CH < 5'd4)
			blit_act[XFER_CH[1:0]] <= 1'b0;
	end

	// Fetched coprocessor words pass through a FIFO
	wire f_valid;
	wire [31:0] f_data;
	wire f_pop = f_valid && cop_st != COP_IDLE && cop_st != COP_WAIT;
	dcam_fifo #(
		.WIDTH(32),
		.DEPTH(`DCAM_FIFO_DEPTH),
		.AW(3)
	) u_fifo (
		.clk(MCLK),
		.rst(RST),
		.in_valid(FETCH_VALID),
		.in_ready(cop_ready),
		.in_data(FETCH_DATA),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	always @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cop_st <= COP_IDLE;
			cop_wait <= 16'h0000;
			cop_jump <= 20'h0_0000;
			cop_jump_do <= 1'b0;
			COP_REG_WRITE <= 1'b0;
			COP_REG_ADDR <= 8'h00;
			COP_REG_DATA <= 16'h0000;
		end else begin
			COP_REG_WRITE <= 1'b0;
			cop_jump_do <= 1'b0;
			case (cop_st)
				COP_IDLE: begin
					if (COP_START)
						cop_st <= COP_FETCH;
				end
				COP_FETCH: begin
					if (f_pop) begin
						case (f_data[31:30])
							`DCAM_OP_MOVE: begin
								COP_REG_WRITE <= 1'b1;
								COP_REG_ADDR <= f_data[23:16];
								COP_REG_DATA <= f_data[15:0];
							end
							`DCAM_OP_SKIP: begin
								if (BEAM_POS >= f_data[15:0])
									cop_st <= COP_SKIP;
							end
							`DCAM_OP_JUMP: begin
								cop_jump <= f_data[19:0];
								cop_jump_do <= 1'b1;
							end
							default: begin
								cop_wait <= f_data[15:0];
								cop_st <= COP_WAIT;
							end
						endcase
					end
				end
				COP_SKIP: begin
					if (f_pop)
						cop_st <= COP_FETCH;
				end
				COP_WAIT: begin
					if (BEAM_POS == cop_wait)
						cop_st <= COP_FETCH;
				end
				default: begin
					cop_st <= COP_IDLE;
				end
			endcase
			if (COP_START)
				cop_st <= COP_FETCH;
		end
	end
endmodule // dcam_top

// *** tb/dcam_props.sv ***
// Port checks for the address multiplexer
`timescale 1ns/1ps
`include "dcam_map.vh"
module dcam_props #(
	parameter TWO_MEG = 0
) (
	input wire MCLK,
	input wire RST,
	input wire [20:1] HOST_ADDR,
	input wire ADDR_STROBE_N,
	input wire MEMORY_SELECT_N,
	input wire REGS_SELECT_N,
	input wire LOWER_BYTE_STROBE_N,
	input wire UPPER_BYTE_STROBE_N,
	input wire HOST_READ_WRITE,
	input wire [9:0] MEM_ADDR_BUS,
	input wire [8:1] REG_DEST_BUS,
	input wire BUS_STEAL_N,
	input wire ROW_STROBE_N,
	input wire ROW_STROBE_BANK0_N,
	input wire ROW_STROBE_BANK1_N,
	input wire COL_STROBE_UPPER_N,
	input wire COL_STROBE_LOWER_N,
	input wire REG_READ_WRITE_OUT,
	input wire COL_PHASE
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	wire mem_req = !ADDR_STROBE_N && !MEMORY_SELECT_N;
	wire reg_req = !ADDR_STROBE_N && !REGS_SELECT_N;
	wire host_col = BUS_STEAL_N && COL_PHASE;
	property p_steal_len;
		$fell(BUS_STEAL_N) |-> !COL_PHASE && !ROW_STROBE_N ##0 !BUS_STEAL_N [*3] ##1 BUS_STEAL_N;
	endproperty
	a_steal_len: assert property (p_steal_len) else $error("bus steal shape wrong");
	property p_refresh;
		!BUS_STEAL_N && REG_DEST_BUS == `DCAM_REF_CODE |-> COL_STROBE_UPPER_N
			&& COL_STROBE_LOWER_N && !ROW_STROBE_N && !ROW_STROBE_BANK0_N && !ROW_STROBE_BANK1_N;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh strobes wrong");
	property p_dma_cas;
		!BUS_STEAL_N && COL_PHASE && REG_DEST_BUS != `DCAM_REF_CODE |-> !COL_STROBE_UPPER_N
			&& !COL_STROBE_LOWER_N && !ROW_STROBE_N && ROW_STROBE_BANK0_N != ROW_STROBE_BANK1_N;
	endproperty
	a_dma_cas: assert property (p_dma_cas) else $error("transfer strobes wrong");
	property p_idle;
		(BUS_STEAL_N && ADDR_STROBE_N) [*4] |-> ROW_STROBE_N && ROW_STROBE_BANK0_N
			&& ROW_STROBE_BANK1_N && COL_STROBE_UPPER_N && COL_STROBE_LOWER_N;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe active while idle");
	property p_row;
		BUS_STEAL_N && !COL_PHASE && $past(mem_req, 3) |->
			MEM_ADDR_BUS == {$past(HOST_ADDR[19], 3), $past(HOST_ADDR[17:9], 3)};
	endproperty
	a_row: assert property (p_row) else $error("host row address wrong");
	property p_col;
		host_col && $past(mem_req, 3) |-> MEM_ADDR_BUS == {$past(HOST_ADDR[20], 3),
			$past(HOST_ADDR[18], 3), $past(HOST_ADDR[8:1], 3)};
	endproperty
	a_col: assert property (p_col) else $error("host column address wrong");
	property p_bank;
		TWO_MEG == 0 && host_col && $past(mem_req, 3) |->
			ROW_STROBE_BANK0_N == $past(HOST_ADDR[19], 3) && ROW_STROBE_BANK1_N != ROW_STROBE_BANK0_N;
	endproperty
	a_bank: assert property (p_bank) else $error("bank strobe wrong");
	property p_bytes;
		host_col && $past(mem_req, 3) |-> COL_STROBE_LOWER_N == $past(LOWER_BYTE_STROBE_N, 3)
			&& COL_STROBE_UPPER_N == $past(UPPER_BYTE_STROBE_N, 3);
	endproperty
	a_bytes: assert property (p_bytes) else $error("column strobe wrong");
	property p_reg;
		BUS_STEAL_N && $past(reg_req, 3) |-> REG_DEST_BUS == $past(HOST_ADDR[8:1], 3)
			&& REG_READ_WRITE_OUT == $past(HOST_READ_WRITE, 3);
	endproperty
	a_reg: assert property (p_reg) else $error("register access wrong");
endmodule // dcam_props

// *** tb/dcam_mem_model.sv ***
// Memory side model answering instruction fetches
`timescale 1ns/1ps
`include "dcam_map.vh"
module dcam_mem_model #(
	parameter LAT = 2
) (
	input wire clk,
	input wire rst,
	input wire done,
	input wire [4:0] ch,
	output reg fv,
	output reg [31:0] fd
);
	reg [31:0] rom [0:3];
	reg [1:0] idx;
	integer cnt;
	initial begin
		rom[0] = 32'h00A5_1234;
		rom[1] = 32'hC000_BEEF;
		rom[2] = 32'h005A_4321;
		rom[3] = 32'hC000_0001;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fv <= 1'b0;
			fd <= 32'h0000_0000;
			idx <= 2'd0;
			cnt <= 0;
		end else begin
			fv <= 1'b0;
			if (cnt == 1) begin
				fv <= 1'b1;
				fd <= rom[idx];
				idx <= idx + 2'd1;
			end else
				fd <= ~fd;
			if (done && ch == `DCAM_CH_COP)
				cnt <= LAT;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule // dcam_mem_model

// *** tb/tb_top.sv ***
// Testbench for the address multiplexer
`timescale 1ns/1ps
`include "dcam_map.vh"
module tb_top;
	reg mclk = 0;
	reg rst = 1;
	reg [20:1] addr = 0;
	reg as_n = 1, ms_n = 1, rs_n = 1, lds_n = 1, uds_n = 1, rw = 1;
	reg [3:0] areq = 0, slot = 0, buse = 0;
	reg dreq = 0, dwr = 0, tick = 0, hbl = 0, cst = 0, pld = 0, bst = 0, dact = 0;
	reg [15:0] beam = 0;
	reg [7:0] spen = 0, pen = 0;
	reg [4:0] psel = 0;
	reg [19:0] pdat = 0, p;
	wire fv, st_n, reg_read_write_out, colp, done, cw;
	wire [31:0] fd;
	wire [9:0] ma;
	wire [8:1] reg_dest_bus;
	wire [4:0] xch;
	wire [7:0] ca;
	wire [15:0] cd;
	integer err_count = 0, samples_checked = 0, cyc = 0, i;
	dcam_top #(.TWO_MEG(0)) dut (
		.MCLK(mclk), .RST(rst), .HOST_ADDR(addr), .ADDR_STROBE_N(as_n),
		.MEMORY_SELECT_N(ms_n), .REGS_SELECT_N(rs_n), .LOWER_BYTE_STROBE_N(lds_n),
		.UPPER_BYTE_STROBE_N(uds_n), .HOST_READ_WRITE(rw), .SLOT_REQUEST_IN(areq),
		.DISK_REQ(dreq), .DISK_WRITE(dwr), .SLOT(slot), .SLOT_TICK(tick), .HBLANK(hbl),
		.DISPLAY_ACTIVE(dact), .BEAM_POS(beam), .BLIT_START(bst), .BLIT_USE(buse),
		.SPRITE_EN(spen), .PLANE_EN(pen), .COP_START(cst), .PTR_LOAD(pld),
		.PTR_SEL(psel), .PTR_DATA(pdat), .FETCH_VALID(fv), .FETCH_DATA(fd),
		.MEM_ADDR_BUS(ma), .REG_DEST_BUS(reg_dest_bus), .BUS_STEAL_N(st_n), .ROW_STROBE_N(),
		.ROW_STROBE_BANK0_N(), .ROW_STROBE_BANK1_N(), .COL_STROBE_UPPER_N(),
		.COL_STROBE_LOWER_N(), .REG_READ_WRITE_OUT(reg_read_write_out), .COL_PHASE(colp),
		.XFER_DONE(done), .XFER_CH(xch), .COP_REG_WRITE(cw), .COP_REG_ADDR(ca),
		.COP_REG_DATA(cd));
	dcam_mem_model #(.LAT(2)) mem (.clk(mclk), .rst(rst), .done(done), .ch(xch),
		.fv(fv), .fd(fd));
	always #2 mclk = ~mclk;
	function [9:0] rowa(input [19:0] v);
		rowa = {v[18], v[16:8]};
	endfunction
	function [9:0] cola(input [19:0] v);
		cola = {v[19], v[17], v[7:0]};
	endfunction
	task summarize;
		begin
			if (err_count == 0 && samples_checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task clk(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	task load(input [4:0] ch, input [19:0] v);
		begin
			@(posedge mclk);
			pld <= 1;
			psel <= ch;
			pdat <= v;
			@(posedge mclk);
			pld <= 0;
			clk(3);
		end
	endtask
	task host(input mem, input [20:1] a, input [1:0] bs, input r);
		begin
			@(posedge mclk);
			addr <= a;
			as_n <= 0;
			ms_n <= !mem;
			rs_n <= mem;
			{uds_n, lds_n} <= bs;
			rw <= r;
			clk(5);
			#1;
			if (mem)
				chk({colp, ma}, {1'b1, a[20], a[18], a[8:1]});
			else
				chk({reg_read_write_out, reg_dest_bus}, {r, a[8:1]});
			@(posedge mclk);
			as_n <= 1;
			ms_n <= 1;
			rs_n <= 1;
			clk(5);
		end
	endtask
	task dma(input [3:0] s, input [4:0] ch, input [19:0] pv, input [7:0] dst);
		integer k;
		begin
			@(posedge mclk);
			slot <= s;
			tick <= 1;
			@(posedge mclk);
			tick <= 0;
			#1;
			for (k = 0; k < 6 && st_n !== 1'b0; k = k + 1)
				@(posedge mclk) #1;
			if (ch == 5'd31) begin
				chk(st_n, 1'b1);
			end else begin
				chk({reg_read_write_out, reg_dest_bus, ma}, {!(ch == `DCAM_CH_BLT + 3 || (ch == `DCAM_CH_DSK && dwr)),
					dst, rowa(pv)});
				@(posedge mclk) #1;
				if (dst != `DCAM_REF_CODE)
					chk(ma, cola(pv));
				for (k = 0; k < 8 && done !== 1'b1; k = k + 1)
					@(posedge mclk) #1;
				chk({done, xch}, {1'b1, ch});
			end
		end
	endtask
	task cop_write(input [7:0] a, input [15:0] d);
		integer k;
		begin
			for (k = 0; k < 40 && cw !== 1'b1; k = k + 1)
				@(posedge mclk) #1;
			chk({cw, ca, cd}, {1'b1, a, d});
		end
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count = err_count + 1;
			summarize;
		end
	end
	initial begin
		i = $urandom(32'h13ff_e3b3);
		clk(5);
		rst <= 0;
		clk(3);
		for (i = 0; i < 12; i = i + 1)
			host(i[0], $urandom, $urandom, $urandom);
		p = $urandom;
		load(`DCAM_CH_REF, p);
		dma(`DCAM_SLOT_REF, `DCAM_CH_REF, p, `DCAM_REF_CODE);
		dma(`DCAM_SLOT_REF, `DCAM_CH_REF, p + 20'h0_0200, `DCAM_REF_CODE);
		@(posedge mclk);
		dreq <= 1;
		dwr <= $urandom;
		p = $urandom;
		load(`DCAM_CH_DSK, p);
		dma(`DCAM_SLOT_DSK, `DCAM_CH_DSK, p, `DCAM_DST_DSK);
		dma(`DCAM_SLOT_DSK, `DCAM_CH_DSK, p + 20'h0_0001, `DCAM_DST_DSK);
		@(posedge mclk);
		dreq <= 0;
		areq <= 4'h1;
		load(`DCAM_CH_AUD, p);
		dma(`DCAM_SLOT_AUD, 5'd31, p, 8'h00);
		@(posedge mclk);
		hbl <= 1;
		dma(`DCAM_SLOT_AUD, `DCAM_CH_AUD, p, `DCAM_DST_AUD);
		@(posedge mclk);
		areq <= 4'h0;
		hbl <= 0;
		spen <= $urandom | 8'h01;
		load(`DCAM_CH_SPR, p);
		dma(`DCAM_SLOT_SPR, `DCAM_CH_SPR, p, `DCAM_DST_SPR);
		@(posedge mclk);
		spen <= 0;
		load(`DCAM_CH_BLT, p);
		load(`DCAM_CH_BLT + 3, ~p);
		bst <= 1;
		buse <= 4'h9;
		@(posedge mclk);
		bst <= 0;
		dma(2, `DCAM_CH_BLT, p, `DCAM_DST_BLT);
		dma(2, `DCAM_CH_BLT + 3, ~p, `DCAM_DST_BLT + 8'h03);
		@(posedge mclk);
		dact <= 1;
		pen <= ($urandom | 8'h02) & 8'hFE;
		load(`DCAM_CH_BPL + 1, p);
		dma(2, `DCAM_CH_BPL + 1, p, `DCAM_DST_BPL + 8'h01);
		@(posedge mclk);
		dact <= 0;
		pen <= 8'h00;
		p = $urandom;
		load(`DCAM_CH_COP, p);
		cst <= 1;
		@(posedge mclk);
		cst <= 0;
		dma(2, `DCAM_CH_COP, p, `DCAM_DST_COP);
		cop_write(8'hA5, 16'h1234);
		dma(2, `DCAM_CH_COP, p + 20'h0_0001, `DCAM_DST_COP);
		clk(10);
		repeat (2)
			dma(2, 5'd31, p, 8'h00);
		@(posedge mclk);
		beam <= 16'hBEEF;
		dma(2, `DCAM_CH_COP, p + 20'h0_0002, `DCAM_DST_COP);
		cop_write(8'h5A, 16'h4321);
		summarize;
	end
endmodule // tb_top
bind dcam_top dcam_props #(.TWO_MEG(TWO_MEG)) u_props (
	.MCLK(MCLK), .RST(RST), .HOST_ADDR(HOST_ADDR), .ADDR_STROBE_N(ADDR_STROBE_N),
	.MEMORY_SELECT_N(MEMORY_SELECT_N), .REGS_SELECT_N(REGS_SELECT_N),
	.LOWER_BYTE_STROBE_N(LOWER_BYTE_STROBE_N), .UPPER_BYTE_STROBE_N(UPPER_BYTE_STROBE_N),
	.HOST_READ_WRITE(HOST_READ_WRITE), .MEM_ADDR_BUS(MEM_ADDR_BUS),
	.REG_DEST_BUS(REG_DEST_BUS), .BUS_STEAL_N(BUS_STEAL_N), .ROW_STROBE_N(ROW_STROBE_N),
	.ROW_STROBE_BANK0_N(ROW_STROBE_BANK0_N), .ROW_STROBE_BANK1_N(ROW_STROBE_BANK1_N),
	.COL_STROBE_UPPER_N(COL_STROBE_UPPER_N), .COL_STROBE_LOWER_N(COL_STROBE_LOWER_N),
	.REG_READ_WRITE_OUT(REG_READ_WRITE_OUT), .COL_PHASE(COL_PHASE));
